// >>> verification/ssb_bringup_test.sv
// self-checking bench: strap capture, power-on reset, staged commits and bring-up pulses
`timescale 1ns/100ps
`default_nettype none
module ssb_bringup_test;
  import ssb_pkg::*;
  localparam int CAL = 4;
  logic clk;
  logic srst;
  logic supplies_good;
  logic rd_q;
  logic [7:0] strap;
  logic [7:0] x;
  logic [7:0] y;
  logic [7:0] exp_v;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int n_tests = 0;
  wire logic [7:0] multifunction_pins_out;
  wire logic [7:0] multifunction_pins_oe_n;
  wire logic reg_wr_en;
  wire logic reg_rd_en;
  wire logic [15:0] reg_addr;
  wire logic [7:0] reg_wdata;
  wire logic [7:0] reg_rdata;
  wire logic internal_reset;
  wire logic [7:0] startup_strap_word;
  wire ssb_strap_t strap_decode;
  wire logic eeprom_done;
  wire logic eeprom_busy;
  wire ssb_active_t cfg_active;
  wire logic cal_start;
  wire logic cal_busy;
  wire logic [7:0] detect_start_mask;
  wire logic detect_start;
  wire logic detect_done;
  wire logic detect_busy;
  wire logic lock_start;
  wire logic dist_sync;
  wire logic [7:0] dist_out_en;
  // pull resistors hold the strap wherever the device leaves a pin floating
  wire logic [7:0] multifunction_pins_in =
    (strap & multifunction_pins_oe_n) | (multifunction_pins_out & ~multifunction_pins_oe_n);
  wire logic [4:0] pulses = {~eeprom_busy, lock_start, detect_start, dist_sync, cal_start};

  ssb_bringup #(.CAL_CYCLES(CAL)) i_ssb_bringup (.clk, .srst, .supplies_good,
    .multifunction_pins_in, .multifunction_pins_out, .multifunction_pins_oe_n, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .internal_reset, .startup_strap_word,
    .strap_decode, .eeprom_done, .eeprom_busy, .cfg_active, .cal_start, .cal_busy,
    .detect_start_mask, .detect_start, .detect_done, .detect_busy, .lock_start, .dist_sync,
    .dist_out_en);

  ssb_host_model i_ssb_host_model (.clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .eeprom_busy, .eeprom_done, .detect_busy, .detect_done);

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_ssb_host_model.acc(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] d);
    exp_q.push_back(d);
    i_ssb_host_model.acc(1'b0, a, 8'h00);
  endtask : rd

  // bounded wait on one entry of pulses; a miss ends the run
  task automatic wait_p(input int b);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (pulses[b] !== 1'b1 && n < 40);
    chk(pulses[b], 1'b1);
    if (pulses[b] !== 1'b1)
      summarize();
  endtask : wait_p

  task automatic do_reset(input logic [7:0] s);
    @(posedge clk);
    srst <= 1'b1;
    strap <= s;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk(multifunction_pins_oe_n, 8'hff);
    @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(negedge clk);
    chk(startup_strap_word, s);
    chk(strap_decode.serial_i2c, |s[2:0]);
    chk(strap_decode.i2c_addr_lsb, s[2:0]);
    chk(strap_decode.load_cond, s[7:3]);
    chk(eeprom_busy, |s[7:3]);
    wait_p(4);
  endtask : do_reset

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // reads are answered one cycle after the strobe is taken
  always @(posedge clk)
    rd_q <= (reg_rd_en === 1'b1) && (srst === 1'b0);
  always @(negedge clk)
    if (rd_q)
    begin
      exp_v = exp_q.pop_front();
      chk(reg_rdata, exp_v);
    end

  initial
  begin
    int n;
    srst = 1'b1;
    supplies_good = 1'b0;
    strap = 8'h00;
    rd_q = 1'b0;
    void'($urandom(61580));
    repeat (2) @(posedge clk);
    supplies_good <= 1'b1;
    do_reset(8'h00);
    do_reset(8'h05);
    x = 8'($urandom());
    do_reset(x | 8'h08);
    // supplies dip and return: the internal pulse alone must reset
    @(posedge clk);
    supplies_good <= 1'b0;
    repeat (4) @(posedge clk);
    supplies_good <= 1'b1;
    n = 0;
    while (internal_reset !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    chk(internal_reset, 1'b1);
    if (internal_reset !== 1'b1)
      summarize();
    n = 0;
    while (internal_reset === 1'b1 && n < 10)
    begin
      chk(multifunction_pins_oe_n, 8'hff);
      @(negedge clk);
      n++;
    end
    chk(n, POR_CYCLES);
    if (internal_reset === 1'b1)
      summarize();
    wait_p(4);
    foreach (CFG_ADDR[k])
      rd(CFG_ADDR[k], 8'h00);
    rd(ADDR_STRAP, strap);
    rd(ADDR_STATUS, {7'h00, |strap[2:0]});
    @(negedge clk);
    chk(cfg_active, 64'h0);
    wr(16'h0900, 8'h5a);
    rd(16'h0900, 8'h00);
    x = 8'($urandom());
    y = 8'($urandom());
    wr(16'h0100, x);
    wr(16'h0202, y);
    @(negedge clk);
    chk(cfg_active.irq_mask, 8'h00);
    rd(16'h0202, y);
    wr(ADDR_COMMIT, 8'h01);
    @(negedge clk);
    chk(cfg_active.system_clock_input_period, x);
    chk(cfg_active.irq_mask, y);
    rd(ADDR_COMMIT, 8'h00);
    wr(16'h0a02, 8'h01);
    wr(ADDR_COMMIT, 8'h01);
    wait_p(0);
    n = 0;
    while (cal_busy === 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk(n, CAL);
    if (cal_busy === 1'b1)
      summarize();
    wr(16'h0a02, 8'h00);
    wr(ADDR_COMMIT, 8'h01);
    y = 8'($urandom()) | 8'h01;
    wr(16'h0400, y);
    wr(ADDR_COMMIT, 8'h01);
    @(negedge clk);
    chk(dist_out_en, 8'h00);
    wr(16'h0a02, 8'h02);
    wr(ADDR_COMMIT, 8'h01);
    wr(16'h0a02, 8'h00);
    wr(ADDR_COMMIT, 8'h01);
    wait_p(1);
    repeat (2) @(negedge clk);
    chk(dist_out_en, y);
    wr(16'h0500, 8'h00);
    wr(ADDR_COMMIT, 8'h01);
    wait_p(3);
    i_ssb_host_model.dly = 8;
    y = 8'($urandom()) | 8'h01;
    wr(16'h0500, 8'h01);
    wr(16'h0a0d, y);
    wr(ADDR_COMMIT, 8'h01);
    wait_p(2);
    chk(detect_start_mask, y);
    chk(detect_busy, 1'b1);
    wait_p(3);
    // an external rising edge on the selected pin must also raise a sync pulse
    wr(16'h0205, 8'h0c);
    wr(ADDR_COMMIT, 8'h01);
    strap <= strap & 8'hef;
    repeat (3) @(posedge clk);
    strap <= strap | 8'h10;
    wait_p(1);
    y = 8'($urandom());
    wr(16'h0201, y);
    wr(16'h0200, 8'hf0);
    @(negedge clk);
    chk(multifunction_pins_oe_n, 8'hff);
    wr(ADDR_COMMIT, 8'h01);
    repeat (2) @(negedge clk);
    chk(multifunction_pins_oe_n, 8'h0f);
    chk(multifunction_pins_out, y);
    summarize();
  end
endmodule : ssb_bringup_test
`default_nettype wire

// >>> verification/ssb_host_model.sv
// host processor, EEPROM loader and reference detector stand-in at the far side
`timescale 1ns/100ps
`default_nettype none
module ssb_host_model (
  input wire logic clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic eeprom_busy,
  output logic eeprom_done,
  input wire logic detect_busy,
  output logic detect_done
);
  // answer delay of loader and detector, raised by the bench for a slow far side
  int dly = 3;
  int ecnt = 0;
  int dcnt = 0;

  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
  end

  // leading edge keeps two accesses out of one time step; data scrambled once released
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= w;
    reg_rd_en <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : acc

  always @(posedge clk)
  begin
    ecnt <= (eeprom_busy === 1'b1) ? ecnt + 1 : 0;
    dcnt <= (detect_busy === 1'b1) ? dcnt + 1 : 0;
    eeprom_done <= (ecnt == dly);
    detect_done <= (dcnt == dly);
  end
endmodule : ssb_host_model
`default_nettype wire

// >>> verilog/ssb_bringup.sv
// power-on reset, strap capture, staged configuration and bring-up sequencing
`timescale 1ns/100ps
`default_nettype none

// Function
// - supplies good gives internal 75 ns reset
// - pins go high-impedance within 45 ns
// - pins float in reset, strap captured on release
// - strap bit n equals multifunction pin n
// - low strap bits zero selects SPI else I2C
// - upper strap bits zero skip EEPROM load
// - nonzero upper bits request EEPROM load, condition
// - commit bit applies settings written so far
// - calibrate set/commit/clear/commit starts calibration; here the first commit with the bit set starts it
// - pins default to undesignated high-impedance inputs
// - interrupt masks closed, irq pin open-drain
// - watchdog disabled after reset
// - distribution output enables disabled after reset
// - manual mode commit starts reference lock
// - auto mode commit starts selected detection
// - sync bit set-clear or sync pin enables outputs
// - parameters grouped into fixed address spaces
module ssb_bringup #(
  parameter int CAL_CYCLES = 64
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic supplies_good,
  input wire logic [ssb_pkg::PIN_COUNT-1:0] multifunction_pins_in,
  output logic [ssb_pkg::PIN_COUNT-1:0] multifunction_pins_out,
  output logic [ssb_pkg::PIN_COUNT-1:0] multifunction_pins_oe_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [ssb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ssb_pkg::DATA_W-1:0] reg_wdata,
  output logic [ssb_pkg::DATA_W-1:0] reg_rdata,
  output logic internal_reset,
  output logic [ssb_pkg::PIN_COUNT-1:0] startup_strap_word,
  output ssb_pkg::ssb_strap_t strap_decode,
  input wire logic eeprom_done,
  output logic eeprom_busy,
  output ssb_pkg::ssb_active_t cfg_active,
  output logic cal_start,
  output logic cal_busy,
  output logic [ssb_pkg::DATA_W-1:0] detect_start_mask,
  output logic detect_start,
  input wire logic detect_done,
  output logic detect_busy,
  output logic lock_start,
  output logic dist_sync,
  output logic [ssb_pkg::DATA_W-1:0] dist_out_en
);
  import ssb_pkg::*;

  localparam logic [7:0] CAL_LOAD = 8'(CAL_CYCLES);

  logic sup_meta_reg, sup_sync_reg, sup_prev_reg;
  logic [PIN_COUNT-1:0] mf_meta_reg, mf_sync_reg, mf_prev_reg;
  logic [1:0] por_cnt_reg;
  logic in_reset_reg;
  logic [PIN_COUNT-1:0] strap_reg;
  ssb_strap_t strap_dec_reg;
  logic eeprom_busy_reg;
  logic [DATA_W-1:0] stage_reg [NUM_CFG];
  logic [DATA_W-1:0] act_reg [NUM_CFG];
  logic [PIN_COUNT-1:0] pin_out_reg, pin_oe_n_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic cal_prev_reg, sync_prev_reg;
  logic cal_start_reg;
  logic [7:0] cal_cnt_reg;
  logic cal_busy_reg;
  logic det_start_reg, det_busy_reg, lock_start_reg;
  logic [DATA_W-1:0] det_mask_reg;
  logic dist_sync_reg, dist_live_reg;
  logic [DATA_W-1:0] dist_en_reg;
  logic int_rst_reg;

  // internal power-on pulse, independent of srst
  wire por_start = sup_sync_reg & ~sup_prev_reg;
  wire core_rst = srst | (por_cnt_reg != 2'h0);
  wire release_evt = in_reset_reg & ~core_rst;

  always_ff @(posedge clk)
  begin
    sup_meta_reg <= supplies_good;
    sup_sync_reg <= sup_meta_reg;
    sup_prev_reg <= sup_sync_reg;
    mf_meta_reg <= multifunction_pins_in;
    mf_sync_reg <= mf_meta_reg;
    mf_prev_reg <= mf_sync_reg;
  end

  always_ff @(posedge clk)
  begin
    if (por_start)
      por_cnt_reg <= POR_LOAD;
    else if (por_cnt_reg != 2'h0)
      por_cnt_reg <= por_cnt_reg - 2'h1;
  end

  always_ff @(posedge clk)
  begin
    in_reset_reg <= core_rst | por_start;
    // pins already float on the start cycle, so the visible pulse keeps the counted width
    int_rst_reg <= core_rst;
  end

  // strap latch: the level at release is held until the next release; eeprom_load pulses for one cycle
  always_ff @(posedge clk)
  begin
    if (release_evt)
    begin
      strap_reg <= mf_sync_reg;
      strap_dec_reg.serial_i2c <= (mf_sync_reg[2:0] != 3'h0);
      strap_dec_reg.i2c_addr_lsb <= mf_sync_reg[2:0];
      strap_dec_reg.eeprom_load <= (mf_sync_reg[7:3] != 5'h00);
      strap_dec_reg.load_cond <= mf_sync_reg[7:3];
    end
    else
      strap_dec_reg.eeprom_load <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (core_rst)
      eeprom_busy_reg <= 1'b0;
    else if (release_evt && mf_sync_reg[7:3] != 5'h00)
      eeprom_busy_reg <= 1'b1;
    else if (eeprom_done)
      eeprom_busy_reg <= 1'b0;
  end

  // address decode by space
  wire [ADDR_W-1:0] space = {reg_addr[ADDR_W-1:8], 8'h00};
  wire space_known = (space == SPACE_SYSTEM_CLOCK_INPUT) | (space == SPACE_PINS) |
    (space == SPACE_DPLL) | (space == SPACE_DIST) | (space == SPACE_REF) |
    (space == SPACE_PROFILE) | (reg_addr[ADDR_W-1:8] == 8'h0a);
  wire commit_pulse = reg_wr_en & ~core_rst & (reg_addr == ADDR_COMMIT) &
    reg_wdata[COMMIT_BIT];
  wire [DATA_W-1:0] rd_chain [NUM_CFG+1];
  wire [NUM_CFG-1:0] cfg_hit;
  assign rd_chain[0] = '0;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CFG; gi++)
    begin : g_cfg
      assign cfg_hit[gi] = space_known & (reg_addr == CFG_ADDR[gi]);
      assign rd_chain[gi+1] = rd_chain[gi] | (cfg_hit[gi] ? stage_reg[gi] : '0);
      always_ff @(posedge clk)
      begin
        if (core_rst)
        begin
          stage_reg[gi] <= CFG_RST[gi];
          act_reg[gi] <= CFG_RST[gi];
        end
        else
        begin
          if (reg_wr_en && cfg_hit[gi])
            stage_reg[gi] <= reg_wdata;
          if (commit_pulse)
            act_reg[gi] <= stage_reg[gi];
        end
      end
    end
  endgenerate

  // pins float unless software drives them after commit
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_pin
      always_ff @(posedge clk)
      begin
        if (core_rst || por_start)
        begin
          pin_oe_n_reg[gi] <= 1'b1;
          pin_out_reg[gi] <= 1'b0;
        end
        else
        begin
          pin_oe_n_reg[gi] <= ~act_reg[IDX_MF_DRIVE_EN][gi];
          pin_out_reg[gi] <= act_reg[IDX_MF_DRIVE_VAL][gi];
        end
      end
    end
  endgenerate

  wire [DATA_W-1:0] status_word = {3'h0, dist_live_reg, det_busy_reg, eeprom_busy_reg,
    cal_busy, strap_dec_reg.serial_i2c};
  wire [DATA_W-1:0] rd_value = (reg_addr == ADDR_STATUS) ? status_word :
    (reg_addr == ADDR_STRAP) ? strap_reg : rd_chain[NUM_CFG];

  // the commit register always reads zero since no stored register stands behind its address
  always_ff @(posedge clk)
  begin
    if (core_rst)
      rdata_reg <= '0;
    else if (reg_rd_en)
      rdata_reg <= rd_value;
  end

  // calibration starts when the committed calibrate bit rises
  wire cal_bit = act_reg[IDX_SYNC_CAL][CAL_BIT];
  wire cal_rise = cal_bit & ~cal_prev_reg;
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      cal_prev_reg <= 1'b0;
      cal_start_reg <= 1'b0;
      cal_cnt_reg <= '0;
      cal_busy_reg <= 1'b0;
    end
    else
    begin
      cal_prev_reg <= cal_bit;
      cal_start_reg <= cal_rise;
      // busy looks one count ahead so the flag comes from a flop, not the counter compare
      cal_busy_reg <= cal_rise | (cal_cnt_reg > 8'h01);
      if (cal_rise)
        cal_cnt_reg <= CAL_LOAD;
      else if (cal_cnt_reg != 8'h00)
        cal_cnt_reg <= cal_cnt_reg - 8'h01;
    end
  end

  // manual mode locks right at commit, auto mode after detection
  wire auto_mode = stage_reg[IDX_REF_CTRL][REF_AUTO_BIT];
  wire det_go = commit_pulse & auto_mode & (stage_reg[IDX_PROFILE_DETECT] != 8'h00);
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      det_start_reg <= 1'b0;
      det_busy_reg <= 1'b0;
      det_mask_reg <= '0;
      lock_start_reg <= 1'b0;
    end
    else
    begin
      det_start_reg <= det_go;
      if (det_go)
        det_mask_reg <= stage_reg[IDX_PROFILE_DETECT];
      if (det_go)
        det_busy_reg <= 1'b1;
      else if (detect_done)
        det_busy_reg <= 1'b0;
      lock_start_reg <= (commit_pulse & ~auto_mode) |
        (det_busy_reg & detect_done);
    end
  end

  // distribution sync: committed sync bit falling after a set, or a pin edge
  wire sync_bit = act_reg[IDX_SYNC_CAL][SYNC_BIT];
  wire [SYNC_PIN_SEL_W-1:0] sync_pin = act_reg[IDX_MF_SYNC_SEL][SYNC_PIN_SEL_W-1:0];
  wire pin_sync = act_reg[IDX_MF_SYNC_SEL][SYNC_PIN_EN_BIT] &
    mf_sync_reg[sync_pin] & ~mf_prev_reg[sync_pin];
  wire sync_evt = (sync_prev_reg & ~sync_bit) | pin_sync;
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      sync_prev_reg <= 1'b0;
      dist_sync_reg <= 1'b0;
      dist_live_reg <= 1'b0;
      dist_en_reg <= '0;
    end
    else
    begin
      sync_prev_reg <= sync_bit;
      dist_sync_reg <= sync_evt;
      if (sync_evt)
        dist_live_reg <= 1'b1;
      dist_en_reg <= dist_live_reg ? act_reg[IDX_DIST_OUT_EN] : '0;
    end
  end

  assign multifunction_pins_out = pin_out_reg;
  assign multifunction_pins_oe_n = pin_oe_n_reg;
  assign reg_rdata = rdata_reg;
  assign internal_reset = int_rst_reg;
  assign startup_strap_word = strap_reg;
  assign strap_decode = strap_dec_reg;
  assign eeprom_busy = eeprom_busy_reg;
  assign cfg_active = '{act_reg[IDX_SYSTEM_CLOCK_INPUT_PERIOD], act_reg[IDX_SYSTEM_CLOCK_INPUT_STAB],
    act_reg[IDX_IRQ_MASK], act_reg[IDX_IRQ_MODE], act_reg[IDX_WDOG_CTRL],
    act_reg[IDX_DPLL_CTRL], act_reg[IDX_REF_CTRL], act_reg[IDX_PROFILE0]};
  assign cal_start = cal_start_reg;
  assign cal_busy = cal_busy_reg;
  assign detect_start_mask = det_mask_reg;
  assign detect_start = det_start_reg;
  assign detect_busy = det_busy_reg;
  assign lock_start = lock_start_reg;
  assign dist_sync = dist_sync_reg;
  assign dist_out_en = dist_en_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  por_width_a: assert property (por_start |=> core_rst [*2] ##1 (!core_rst || por_start))
    else $error("internal reset pulse has wrong width");
  pins_float_a: assert property (por_start |=> (&multifunction_pins_oe_n))
    else $error("pins not high-impedance after power-on start");
  reset_float_a: assert property (core_rst |=> (&multifunction_pins_oe_n))
    else $error("pins driven during reset");
  strap_capture_a: assert property (release_evt |=> startup_strap_word == $past(mf_sync_reg))
    else $error("strap word differs from pins at release");
  serial_mode_a: assert property (release_evt |=>
    strap_decode.serial_i2c == ($past(mf_sync_reg[2:0]) != 3'h0))
    else $error("serial protocol choice wrong");
  eeprom_skip_a: assert property (release_evt && mf_sync_reg[7:3] == 5'h00 |=>
    !strap_decode.eeprom_load && !eeprom_busy)
    else $error("eeprom load requested with zero strap");
  eeprom_load_a: assert property (release_evt && mf_sync_reg[7:3] != 5'h00 |=>
    strap_decode.eeprom_load && strap_decode.load_cond == $past(mf_sync_reg[7:3]))
    else $error("eeprom load not requested");
  commit_apply_a: assert property (commit_pulse |=>
    cfg_active.irq_mask == $past(stage_reg[IDX_IRQ_MASK]))
    else $error("commit did not apply staged value");
  stage_hold_a: assert property (!commit_pulse && !core_rst |=> $stable(cfg_active))
    else $error("active settings changed without commit");
  cal_run_a: assert property ($rose(cal_bit) |=> cal_start ##1 cal_busy)
    else $error("calibration did not start");
  sync_live_a: assert property (sync_evt |=> dist_sync ##1 dist_live_reg)
    else $error("sync event did not enable outputs");
  defaults_a: assert property (core_rst |=> cfg_active.wdog_ctrl == 8'h00 &&
    cfg_active.irq_mask == 8'h00 && dist_out_en == 8'h00)
    else $error("reset defaults wrong");
  manual_lock_a: assert property (commit_pulse && !auto_mode |=> lock_start)
    else $error("manual commit did not start lock");
  detect_go_a: assert property (det_go |=> detect_start && detect_busy &&
    detect_start_mask == $past(stage_reg[IDX_PROFILE_DETECT]))
    else $error("detection did not start with staged mask");
  auto_lock_a: assert property (detect_busy && detect_done |=> lock_start)
    else $error("lock did not follow detection");
  eeprom_end_a: assert property (eeprom_busy && eeprom_done && !release_evt |=>
    !eeprom_busy)
    else $error("eeprom busy did not end");

endmodule : ssb_bringup

`default_nettype wire

// >>> verilog/ssb_pkg.sv
// constants, register map and carrier types for the startup strap and bring-up block
package ssb_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int POR_PULSE_NS = 75;
  localparam int PIN_HIZ_MAX_NS = 45;
  // least time rounds up, longest time rounds down, never below one cycle
  localparam int POR_CYCLES_RAW = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CYCLES = (POR_CYCLES_RAW < 1) ? 1 : POR_CYCLES_RAW;
  localparam int HIZ_CYCLES_RAW = PIN_HIZ_MAX_NS / CLK_PERIOD_NS;
  localparam int HIZ_CYCLES = (HIZ_CYCLES_RAW < 1) ? 1 : HIZ_CYCLES_RAW;
  localparam logic [1:0] POR_LOAD = 2'(POR_CYCLES);

  localparam int PIN_COUNT = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int MODE_LSB_W = 3;
  localparam int LOAD_COND_W = 5;

  // address spaces
  localparam logic [ADDR_W-1:0] SPACE_SYSTEM_CLOCK_INPUT = 16'h0100;
  localparam logic [ADDR_W-1:0] SPACE_PINS = 16'h0200;
  localparam logic [ADDR_W-1:0] SPACE_DPLL = 16'h0300;
  localparam logic [ADDR_W-1:0] SPACE_DIST = 16'h0400;
  localparam logic [ADDR_W-1:0] SPACE_REF = 16'h0500;
  localparam logic [ADDR_W-1:0] SPACE_PROFILE = 16'h0600;

  localparam logic [ADDR_W-1:0] ADDR_COMMIT = 16'h0005;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'h0d00;
  localparam logic [ADDR_W-1:0] ADDR_STRAP = 16'h0d01;

  localparam int COMMIT_BIT = 0;
  localparam int CAL_BIT = 0;
  localparam int SYNC_BIT = 1;
  localparam int REF_AUTO_BIT = 0;
  localparam int SYNC_PIN_EN_BIT = 3;
  localparam int SYNC_PIN_SEL_W = 3;

  // staged configuration entries
  localparam int NUM_CFG = 14;
  localparam int IDX_SYSTEM_CLOCK_INPUT_PERIOD = 0;
  localparam int IDX_SYSTEM_CLOCK_INPUT_STAB = 1;
  localparam int IDX_MF_DRIVE_EN = 2;
  localparam int IDX_MF_DRIVE_VAL = 3;
  localparam int IDX_IRQ_MASK = 4;
  localparam int IDX_IRQ_MODE = 5;
  localparam int IDX_WDOG_CTRL = 6;
  localparam int IDX_MF_SYNC_SEL = 7;
  localparam int IDX_DPLL_CTRL = 8;
  localparam int IDX_DIST_OUT_EN = 9;
  localparam int IDX_REF_CTRL = 10;
  localparam int IDX_PROFILE0 = 11;
  localparam int IDX_SYNC_CAL = 12;
  localparam int IDX_PROFILE_DETECT = 13;

  localparam logic [ADDR_W-1:0] CFG_ADDR [NUM_CFG] = '{
    16'h0100, 16'h0101, 16'h0200, 16'h0201, 16'h0202, 16'h0203, 16'h0204,
    16'h0205, 16'h0300, 16'h0400, 16'h0500, 16'h0600, 16'h0a02, 16'h0a0d};
  // masks closed, open-drain irq, watchdog off, outputs off, pins undriven
  localparam logic [DATA_W-1:0] CFG_RST [NUM_CFG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  typedef struct packed {
    logic [DATA_W-1:0] system_clock_input_period;
    logic [DATA_W-1:0] system_clock_input_stab;
    logic [DATA_W-1:0] irq_mask;
    logic [DATA_W-1:0] irq_mode;
    logic [DATA_W-1:0] wdog_ctrl;
    logic [DATA_W-1:0] dpll_ctrl;
    logic [DATA_W-1:0] ref_ctrl;
    logic [DATA_W-1:0] profile0;
  } ssb_active_t;

  typedef struct packed {
    logic serial_i2c;
    logic [MODE_LSB_W-1:0] i2c_addr_lsb;
    logic eeprom_load;
    logic [LOAD_COND_W-1:0] load_cond;
  } ssb_strap_t;

endpackage : ssb_pkg
